// File: rtl/vic_pkg.sv
// ==============================================================
// Shared constants and types for the vectored interrupt controller
package vic_pkg;

	// ==========================================================
	// Source count and index width
	localparam int NUM_SRC    = 19;  // Maskable sources, order 0..18
	localparam int IDX_W      = 5;   // Width of an order number
	localparam int XEN_W      = 12;  // Enables for orders 7..18
	localparam int NUM_HW_CLR = 4;   // Orders 0..3 cleared on vectoring

	// ==========================================================
	// Register byte addresses on APB
	localparam logic [7:0] ADDR_IE   = 8'hA8;  // interrupt_enable
	localparam logic [7:0] ADDR_XEN  = 8'hAC;  // Extended enables
	localparam logic [7:0] ADDR_PRIO = 8'hB8;  // Priority levels
	localparam logic [7:0] ADDR_STAT = 8'hC0;  // Status, read only

	// ==========================================================
	// Reset values
	localparam logic [7:0]  IE_RESET   = 8'h00;
	localparam logic [11:0] XEN_RESET  = 12'h000;
	localparam logic [18:0] PRIO_RESET = 19'h0_0000;

	// ==========================================================
	// Field positions
	localparam int GE_BIT       = 7;   // global_irq_enable
	localparam int IE_SRC_MSB   = 6;   // Bits 6..0 mask orders 6..0
	localparam int STAT_ACT_LO  = 24;  // Low level in service
	localparam int STAT_ACT_HI  = 25;  // High level in service
	localparam int STAT_REQ     = 26;  // Request to core standing
	localparam int STAT_IDX_LSB = 27;  // Held order number, 5 bits

	// ==========================================================
	// Vector addresses
	localparam logic [15:0] RESET_VEC = 16'h0000;
	localparam logic [15:0] VEC_BASE  = 16'h0003;
	localparam logic [15:0] VEC_STEP  = 16'h0008;

	// ==========================================================
	// Request state, Gray along idle-request and idle-holdoff
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_REQ  = 2'b01,
		ST_HOLD = 2'b10
	} vic_state_type;

	// Request to the CPU core
	typedef struct packed {
		logic        req;
		logic [15:0] vector;
	} vic_cpu_type;

	// Pending flags held by the peripherals
	typedef struct packed {
		logic spi1_flag;
		logic rtc_osc_fail_flag;
		logic port_match_flag;
		logic supply_early_warn_flag;
		logic timer3_flag;
		logic cmp1_flag;
		logic cmp0_flag;
		logic pca_flag;
		logic adc_done_flag;
		logic adc_window_flag;
		logic rtc_alarm_flag;
		logic smbus_flag;
		logic spi0_flag;
		logic timer2_high_ovf_flag;
		logic timer2_low_ovf_flag;
		logic uart_tx_done_flag;
		logic uart_rx_done_flag;
		logic timer1_ovf_flag;
		logic ext1_flag;
		logic timer0_ovf_flag;
		logic ext0_flag;
	} vic_src_type;

endpackage

// File: rtl/vic_ctrl.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ps

module vic_ctrl (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  vic_pkg::vic_src_type       src,
	output vic_pkg::vic_cpu_type       irq,
	input  wire logic                  irq_ack,
	input  wire logic                  reti_done,
	input  wire logic                  instr_done,
	output logic [vic_pkg::NUM_HW_CLR-1:0] hw_clear
);

	// ==========================================================
	// Storage
	logic [7:0]                      ie_reg;       // interrupt_enable
	logic [vic_pkg::XEN_W-1:0]       xen_reg;      // Extended enables
	logic [vic_pkg::NUM_SRC-1:0]     prio_reg;     // 1 = high level
	logic                            act_lo_reg;   // Low ISR running
	logic                            act_hi_reg;   // High ISR running
	logic                            cur_lvl_reg;  // Level of held req
	logic [vic_pkg::IDX_W-1:0]       cur_idx_reg;  // Order of held req
	vic_pkg::vic_state_type          state_reg;    // Request state
	vic_pkg::vic_state_type          state_next;
	vic_pkg::vic_cpu_type            irq_reg;      // Core request
	logic [vic_pkg::NUM_HW_CLR-1:0]  hw_clear_reg; // Clear pulses
	logic [31:0]                     prdata_reg;   // Read data
	logic                            pready_reg;   // Access answer
	logic                            pslverr_reg;  // Unmapped answer

	// ==========================================================
	// Source gathering
	logic [vic_pkg::NUM_SRC-1:0] pend;    // Pending by order
	logic [vic_pkg::NUM_SRC-1:0] en_vec;  // Per-source masks
	logic [vic_pkg::NUM_SRC-1:0] elig;    // Pending and enabled
	logic [vic_pkg::NUM_SRC-1:0] hi_req;  // Eligible, high level
	logic [vic_pkg::NUM_SRC-1:0] lo_req;  // Eligible, low level

	// Multi-flag sources OR their flags into one request
	// Oscillator-fail comes in from the indirect register space
	assign pend = {src.spi1_flag,
		src.rtc_osc_fail_flag,
		src.port_match_flag,
		src.supply_early_warn_flag,
		src.timer3_flag, src.cmp1_flag, src.cmp0_flag,
		src.pca_flag, src.adc_done_flag, src.adc_window_flag,
		src.rtc_alarm_flag, src.smbus_flag, src.spi0_flag,
		src.timer2_low_ovf_flag | src.timer2_high_ovf_flag,
		src.uart_rx_done_flag | src.uart_tx_done_flag,
		src.timer1_ovf_flag,
		src.ext1_flag,
		src.timer0_ovf_flag,
		src.ext0_flag};

	// Bits 6..0 mask orders 6..0, extended bits the rest
	assign en_vec = {xen_reg, ie_reg[vic_pkg::IE_SRC_MSB:0]};

	// Per-source gating by mask, global enable and level
	genvar gi;
	generate
		for (gi = 0; gi < vic_pkg::NUM_SRC; gi++) begin : g_src
			// Global bit overrides every mask
			assign elig[gi] = pend[gi] & en_vec[gi]
				& ie_reg[vic_pkg::GE_BIT];
			assign hi_req[gi] = elig[gi] & prio_reg[gi];
			assign lo_req[gi] = elig[gi] & ~prio_reg[gi];
		end
	endgenerate

	// ==========================================================
	// Arbitration
	// Lowest set bit gives the winning order number
	function automatic logic [vic_pkg::IDX_W-1:0] first_set(
		input logic [vic_pkg::NUM_SRC-1:0] v);
		first_set = '0;
		for (int i = vic_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_set = vic_pkg::IDX_W'(i);
			end
		end
	endfunction

	logic                      any_hi;   // Some high request
	logic                      any_lo;   // Some low request
	logic                      win_lvl;  // Winner level
	logic [vic_pkg::IDX_W-1:0] win_idx;  // Winner order
	logic                      win_ok;   // Winner may preempt
	logic [15:0]               win_vec;  // Winner vector
	logic                      still;    // Held source still valid
	logic                      ack_take; // Core takes the request

	assign any_hi  = |hi_req;
	assign any_lo  = |lo_req;
	// High level first, order only within a level
	assign win_lvl = any_hi;
	assign win_idx = any_hi ? first_set(hi_req)
		: first_set(lo_req);
	// Nothing preempts high; only high preempts low
	assign win_ok  = act_hi_reg ? 1'b0
		: act_lo_reg ? any_hi : (any_hi | any_lo);
	assign win_vec = 16'(vic_pkg::VEC_BASE
		+ 16'(win_idx) * vic_pkg::VEC_STEP);
	assign still    = elig[cur_idx_reg];
	assign ack_take = irq_ack & (state_reg == vic_pkg::ST_REQ);

	// ==========================================================
	// Request sequencing
	// Decision taken fresh every cycle
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			vic_pkg::ST_IDLE: begin
				if (reti_done) begin
					state_next = vic_pkg::ST_HOLD;
				end else if (win_ok) begin
					state_next = vic_pkg::ST_REQ;
				end
			end
			vic_pkg::ST_REQ: begin
				// Held until taken, dropped if source went away
				if (ack_take || !still) begin
					state_next = vic_pkg::ST_IDLE;
				end
			end
			vic_pkg::ST_HOLD: begin
				// One instruction runs before a new request
				if (instr_done) begin
					state_next = vic_pkg::ST_IDLE;
				end
			end
			default: begin
				state_next = vic_pkg::ST_IDLE;
			end
		endcase
	end

	// State and held request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg   <= vic_pkg::ST_IDLE;
			cur_idx_reg <= '0;
			cur_lvl_reg <= 1'b0;
			irq_reg     <= '{req: 1'b0, vector: vic_pkg::RESET_VEC};
		end else begin
			state_reg   <= state_next;
			irq_reg.req <= (state_next == vic_pkg::ST_REQ);
			// Vector latched on entry only, stable while held
			if (state_reg != vic_pkg::ST_REQ
				&& state_next == vic_pkg::ST_REQ) begin
				cur_idx_reg    <= win_idx;
				cur_lvl_reg    <= win_lvl;
				irq_reg.vector <= win_vec;
			end
		end
	end

	// In-service levels, pushed on acknowledge, popped on return
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_lo_reg <= 1'b0;
			act_hi_reg <= 1'b0;
		end else if (ack_take) begin
			act_hi_reg <= act_hi_reg | cur_lvl_reg;
			act_lo_reg <= act_lo_reg | ~cur_lvl_reg;
		end else if (reti_done) begin
			// Low routine resumes once high one returns
			if (act_hi_reg) begin
				act_hi_reg <= 1'b0;
			end else begin
				act_lo_reg <= 1'b0;
			end
		end
	end

	// Hardware clear pulse for external and timer 0/1 flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hw_clear_reg <= '0;
		end else if (ack_take
			&& cur_idx_reg < vic_pkg::IDX_W'(vic_pkg::NUM_HW_CLR)) begin
			hw_clear_reg <= vic_pkg::NUM_HW_CLR'(
				4'h1 << cur_idx_reg[1:0]);
		end else begin
			hw_clear_reg <= '0;
		end
	end

	// ==========================================================
	// APB slave
	logic        setup;     // Setup phase
	logic        wr_take;   // Write completes this edge
	logic        hit_ie;    // Address decodes
	logic        hit_xen;
	logic        hit_prio;
	logic        hit_stat;
	logic        mapped;    // Any register hit
	logic [31:0] stat_word; // Status view
	logic [31:0] rd_mux;    // Read selection

	assign setup    = psel & ~penable;
	assign wr_take  = psel & penable & pready_reg & pwrite;
	assign hit_ie   = (paddr == vic_pkg::ADDR_IE);
	assign hit_xen  = (paddr == vic_pkg::ADDR_XEN);
	assign hit_prio = (paddr == vic_pkg::ADDR_PRIO);
	assign hit_stat = (paddr == vic_pkg::ADDR_STAT);
	assign mapped   = hit_ie | hit_xen | hit_prio | hit_stat;

	// Held order, request, levels and raw pending flags
	assign stat_word = {cur_idx_reg, irq_reg.req, act_hi_reg,
		act_lo_reg, 5'h00, pend};
	assign rd_mux = hit_ie ? {24'h00_0000, ie_reg}
		: hit_xen  ? {20'h0_0000, xen_reg}
		: hit_prio ? {13'h0000, prio_reg}
		: hit_stat ? stat_word : 32'h0000_0000;

	// Answer one cycle after setup, zero wait in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else begin
			pready_reg  <= setup;
			pslverr_reg <= setup & ~mapped;
			if (setup) begin
				prdata_reg <= rd_mux;
			end
		end
	end

	// Writable registers, all interrupts off after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ie_reg   <= vic_pkg::IE_RESET;
			xen_reg  <= vic_pkg::XEN_RESET;
			prio_reg <= vic_pkg::PRIO_RESET;
		end else if (wr_take) begin
			if (hit_ie) begin
				ie_reg <= pwdata[7:0];
			end
			if (hit_xen) begin
				xen_reg <= pwdata[vic_pkg::XEN_W-1:0];
			end
			if (hit_prio) begin
				prio_reg <= pwdata[vic_pkg::NUM_SRC-1:0];
			end
		end
	end

	// ==========================================================
	// Outputs straight from flops
	assign irq      = irq_reg;
	assign hw_clear = hw_clear_reg;
	assign prdata   = prdata_reg;
	assign pready   = pready_reg;
	assign pslverr  = pslverr_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_ge_off;
		!ie_reg[vic_pkg::GE_BIT] |=> !irq_reg.req;
	endproperty
	a_ge_off: assert property (p_ge_off)
		else $error("request with global enable off");

	property p_mask_in;
		$rose(irq_reg.req) |-> ((($past(en_vec) >> cur_idx_reg)
			& 19'h0_0001)
			!= 19'h0_0000);
	endproperty
	a_mask_in: assert property (p_mask_in)
		else $error("request from masked source");

	property p_spi0_mask;
		(!ie_reg[6] && !$past(ie_reg[6]))
			|-> !(irq_reg.req && cur_idx_reg == 5'd6);
	endproperty
	a_spi0_mask: assert property (p_spi0_mask)
		else $error("first SPI request while masked");

	property p_vector;
		irq_reg.req |-> irq_reg.vector
			== 16'h0003 + {8'h00, cur_idx_reg, 3'b000};
	endproperty
	a_vector: assert property (p_vector)
		else $error("vector does not match order");

	property p_order;
		$rose(irq_reg.req) |-> ((($past(elig) & ~({19{cur_lvl_reg}}
			^ $past(prio_reg))) << (5'd19 - cur_idx_reg))
			& 19'h7_FFFF) == 19'h0_0000;
	endproperty
	a_order: assert property (p_order)
		else $error("lower order at same level skipped");

	property p_level;
		$rose(irq_reg.req) && !cur_lvl_reg |-> $past(hi_req) == '0;
	endproperty
	a_level: assert property (p_level)
		else $error("low level chosen over high");

	property p_hw_clear;
		ack_take && cur_idx_reg == 5'd1 |=> hw_clear_reg == 4'b0010
			##1 hw_clear_reg == 4'b0000;
	endproperty
	a_hw_clear: assert property (p_hw_clear)
		else $error("timer 0 flag not cleared once");

	property p_no_preempt_hi;
		act_hi_reg |-> !irq_reg.req;
	endproperty
	a_no_preempt_hi: assert property (p_no_preempt_hi)
		else $error("high routine preempted");

	property p_detect;
		state_reg == vic_pkg::ST_IDLE && !reti_done && win_ok
			|=> irq_reg.req;
	endproperty
	a_detect: assert property (p_detect)
		else $error("request not raised next cycle");

	property p_after_reti;
		reti_done && state_reg == vic_pkg::ST_IDLE
			|=> !irq_reg.req [*2];
	endproperty
	a_after_reti: assert property (p_after_reti)
		else $error("request before one instruction");

	property p_hold;
		irq_reg.req && !irq_ack |=> $stable(irq_reg.vector);
	endproperty
	a_hold: assert property (p_hold)
		else $error("vector moved before acknowledge");

endmodule // vic_ctrl

// File: tb/vic_core_model.sv
`timescale 1ns/1ps
// ==========================================================
// Far side: peripheral flag holders and a CPU core taking requests
module vic_core_model (
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic [20:0]    flag_set,
	input  wire logic [20:0]    flag_clr,
	input  wire logic [3:0]     ack_dly,
	input  vic_pkg::vic_cpu_type irq,
	input  wire logic [3:0]     hw_clear,
	output vic_pkg::vic_src_type src,
	output logic                irq_ack
);
	logic [3:0] wait_reg;  // Cycles the request has stood unanswered

	// Flags: set by events, cleared by software or on vectoring
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src <= '0;
		end else begin
			src <= (src | flag_set) & ~flag_clr & ~{17'h0_0000, hw_clear};
		end
	end

	// Core: answers after ack_dly cycles, one pulse per request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ack  <= 1'b0;
			wait_reg <= 4'h0;
		end else if (irq_ack || !irq.req) begin
			// Request gone or just taken: start over
			irq_ack  <= 1'b0;
			wait_reg <= 4'h0;
		end else if (wait_reg >= ack_dly) begin
			irq_ack <= 1'b1;
		end else begin
			wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule // vic_core_model

// File: tb/tb_vic_ctrl.sv
`timescale 1ns/1ps
// ==========================================================
// Bench for the vectored interrupt controller
module tb_vic_ctrl;
	logic                 pclk;
	logic                 presetn;
	logic                 psel;
	logic                 penable;
	logic                 pwrite;
	logic [7:0]           paddr;
	logic [31:0]          pwdata;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	vic_pkg::vic_src_type src;
	vic_pkg::vic_cpu_type irq;
	logic                 irq_ack;
	logic                 reti_done;
	logic                 instr_done;
	logic [3:0]           hw_clear;
	logic [20:0]          flag_set;   // Flag events into the model
	logic [20:0]          flag_clr;   // Software clears into the model
	logic [3:0]           ack_dly;    // Core answer delay
	int                   err_total;
	int                   samples_checked;

	// ==========================================================
	// Instances
	vic_ctrl dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .src(src), .irq(irq),
		.irq_ack(irq_ack), .reti_done(reti_done),
		.instr_done(instr_done), .hw_clear(hw_clear)
	);
	vic_core_model core (
		.pclk(pclk), .presetn(presetn), .flag_set(flag_set),
		.flag_clr(flag_clr), .ack_dly(ack_dly), .irq(irq),
		.hw_clear(hw_clear), .src(src), .irq_ack(irq_ack)
	);

	// ==========================================================
	// Shared tasks
	task automatic check(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// Verdict and end of run
	task automatic wrap_up;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		check("pready", 32'h0000_0001, {31'h0000_0000, pready});
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic xe);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		check("prdata", x, r);
		check("pslverr", {31'h0000_0000, xe}, {31'h0000_0000, e});
	endtask

	// Flag events and software clears, one cycle each
	task automatic flags(input logic [20:0] s, input logic [20:0] c);
		flag_set <= s;
		flag_clr <= c;
		@(posedge pclk);
		flag_set <= 21'h00_0000;
		flag_clr <= 21'h00_0000;
		@(posedge pclk);
	endtask

	// Core pulse: return from interrupt or one instruction done
	task automatic pulse(input logic r);
		reti_done  <= r;
		instr_done <= !r;
		@(posedge pclk);
		reti_done  <= 1'b0;
		instr_done <= 1'b0;
		@(posedge pclk);
	endtask

	// End of a routine: software clear, return, next instruction
	task automatic finish_isr(input logic [20:0] c);
		flags(21'h00_0000, c);
		pulse(1'b1);
		pulse(1'b0);
	endtask

	// Request must stay low for n cycles
	task automatic no_req(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(posedge pclk);
			seen = seen | irq.req;
		end
		check("irq_req idle", 32'h0000_0000, {31'h0000_0000, seen});
	endtask

	// Request with vector v, held until the core takes it
	task automatic serve(input logic [15:0] v);
		int n;
		n = 0;
		while (irq.req !== 1'b1 && n < 6) begin
			@(posedge pclk);
			n++;
		end
		check("irq_req", 32'h0000_0001, {31'h0000_0000, irq.req});
		n = 0;
		while (irq_ack !== 1'b1 && n < 20) begin
			check("vector", {16'h0000, v}, {16'h0000, irq.vector});
			@(posedge pclk);
			n++;
		end
		@(posedge pclk);
		check("irq_req taken", 32'h0000_0000, {31'h0000_0000, irq.req});
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs;
		rd(vic_pkg::ADDR_IE, 32'h0000_0000, 1'b0);
		rd(vic_pkg::ADDR_XEN, 32'h0000_0000, 1'b0);
		rd(vic_pkg::ADDR_PRIO, 32'h0000_0000, 1'b0);
		wr(8'h10, 32'hFFFF_FFFF);
		rd(8'h10, 32'h0000_0000, 1'b1);
		wr(vic_pkg::ADDR_IE, 32'h0000_00A5);
		rd(vic_pkg::ADDR_IE, 32'h0000_00A5, 1'b0);
		wr(vic_pkg::ADDR_IE, 32'h0000_0000);
	endtask

	// Global enable off holds all back, then lowest order wins
	task automatic t_global;
		wr(vic_pkg::ADDR_IE, 32'h0000_007F);
		flags(21'h00_01FF, 21'h00_0000);
		no_req(10);
		wr(vic_pkg::ADDR_IE, 32'h0000_00FF);
		serve(16'h0003);
		finish_isr(21'h00_01FF);
	endtask

	// Each flag of orders 0..6: masked, then enabled alone
	task automatic t_mask;
		int o;
		for (int b = 0; b < 9; b++) begin
			o = b < 4 ? b : (b < 8 ? (b + 4) / 2 : 6);
			wr(vic_pkg::ADDR_IE, {24'h00_0000, 8'hFF ^ (8'h01 << o)});
			flags(21'h00_0001 << b, 21'h00_0000);
			no_req(4);
			wr(vic_pkg::ADDR_IE, {24'h00_0000, 8'h80 | (8'h01 << o)});
			serve(16'(3 + 8 * o));
			// Clear pulse lands in the model one edge later
			@(posedge pclk);
			check("flag after vectoring", (b < 4) ? 0 : 1, {31'h0, src[b]});
			finish_isr(21'h00_0001 << b);
		end
	endtask

	// Two levels: high first, no preemption of high, low preempted
	task automatic t_prio;
		wr(vic_pkg::ADDR_XEN, 32'h0000_0FFF);
		wr(vic_pkg::ADDR_PRIO, 32'h0004_0000);
		wr(vic_pkg::ADDR_IE, 32'h0000_00FF);
		flags(21'h10_0200, 21'h00_0000);
		serve(16'h0093);
		no_req(6);
		finish_isr(21'h10_0000);
		serve(16'h003B);
		flags(21'h00_0001, 21'h00_0000);
		no_req(5);
		ack_dly <= 4'h6;
		flags(21'h10_0000, 21'h00_0000);
		serve(16'h0093);
		ack_dly <= 4'h1;
		finish_isr(21'h10_0000);
		no_req(5);
		pulse(1'b1);
		pulse(1'b0);
		serve(16'h0003);
		finish_isr(21'h00_0200);
		wr(vic_pkg::ADDR_PRIO, 32'h0000_0000);
		wr(vic_pkg::ADDR_XEN, 32'h0000_0000);
	endtask

	// Flag left set after return: one instruction, then again
	task automatic t_reenter;
		wr(vic_pkg::ADDR_IE, 32'h0000_0090);
		flags(21'h00_0010, 21'h00_0000);
		serve(16'h0023);
		pulse(1'b1);
		no_req(4);
		pulse(1'b0);
		serve(16'h0023);
		finish_isr(21'h00_0010);
	endtask

	// Supply warning kept out by its enable alone; oscillator fail
	task automatic t_warn;
		wr(vic_pkg::ADDR_IE, 32'h0000_0080);
		flags(21'h0A_0000, 21'h00_0000);
		no_req(4);
		wr(vic_pkg::ADDR_XEN, 32'h0000_0400);
		serve(16'h008B);
		finish_isr(21'h08_0000);
		wr(vic_pkg::ADDR_XEN, 32'h0000_0100);
		serve(16'h007B);
		wr(vic_pkg::ADDR_XEN, 32'h0000_0000);
		pulse(1'b1);
		pulse(1'b0);
		no_req(6);
	endtask

	// ==========================================================
	// Clock, reset, sequence and watchdog
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, reti_done, instr_done} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		flag_set = 21'h00_0000;
		flag_clr = 21'h00_0000;
		ack_dly = 4'h1;
		err_total = 0;
		samples_checked = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_global;
		t_mask;
		t_prio;
		t_reenter;
		t_warn;
		wrap_up;
	end

	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		wrap_up;
	end
endmodule // tb_vic_ctrl
